/* File: rtl/sbi_pkg.sv */
// shared constants and carrier types for the skip, branch and increment decoder
package sbi_pkg;

    // ----------------------------------------------------------------
    // opcode fields
    // ----------------------------------------------------------------
    localparam logic [5:0] OP_DEC_SKIP = 6'h0b;   // 00 1011 dfff ffff
    localparam logic [5:0] OP_INC_FILE = 6'h0a;   // 00 1010 dfff ffff
    localparam logic [2:0] OP_JUMP = 3'h5;        // 10 1kkk kkkk kkkk
    localparam int DEST_BIT = 7;
    localparam int JUMP_HI_LSB = 3;               // upper latch bits 4:3

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [12:0] PC_RST = 13'h0000;
    localparam logic [6:0] ADDR_RST = 7'h00;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        KIND_OTHER,
        KIND_DEC_SKIP,
        KIND_INC,
        KIND_JUMP
    } op_kind_t;

    typedef struct packed {
        logic valid;      // instruction word presented this cycle
        logic [13:0] word;
    } instr_t;

    typedef struct packed {
        logic accum_we;   // write result to accumulator
        logic file_we;    // write result to file register
        logic [6:0] addr;
        logic [7:0] data;
    } result_t;

    typedef struct packed {
        logic zero_we;
        logic zero_val;
    } flag_t;

    typedef struct packed {
        logic pc_load;    // branch taken: load pc and flush prefetch
        logic [12:0] pc;
        logic discard;    // drop the prefetched word, run idle op
    } flow_t;

endpackage

/* File: rtl/sbi_alu.sv */
// combinational adder that steps an 8-bit value up or down by one
`timescale 1ns/100ps
module sbi_alu
(
    // operand
    input wire logic [7:0] operand_i,
    input wire logic down_i,
    // result
    output logic [7:0] result_o,
    output logic zero_o
);

    // wraps modulo 256, so 0xff + 1 gives 0x00 and 0x00 - 1 gives 0xff
    always_comb
    begin
        result_o = down_i ? 8'(operand_i - 8'h01) : 8'(operand_i + 8'h01);
        zero_o = (result_o == 8'h00);
    end

endmodule

/* File: rtl/skip_branch_increment_decode.sv */
// decode and execute for decrement-skip, absolute jump and increment
`timescale 1ns/100ps

// How it works
// - decrement-skip subtracts one, flags untouched
// - dest bit 0 to accumulator, 1 to file
// - zero result discards prefetch, idle slot follows
// - jump loads eleven-bit literal into pc low
// - pc bits 12:11 from upper latch 4:3
// - jump takes two cycles, flags untouched
// - increment adds one, updates zero, one cycle
module skip_branch_increment_decode
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // instruction and operands
    input wire sbi_pkg::instr_t instr_i,
    input wire logic [7:0] file_data_i,
    input wire logic [7:0] pc_upper_latch_i,
    // operand read address
    output logic [6:0] file_addr_o,
    // results
    output sbi_pkg::result_t result_o,
    output sbi_pkg::flag_t flag_o,
    output sbi_pkg::flow_t flow_o
);

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    sbi_pkg::op_kind_t kind;
    logic [7:0] alu_result;
    logic alu_zero;
    logic slot_idle_reg;
    logic slot_idle_next;

    // shared decode of the opcode field
    function automatic sbi_pkg::op_kind_t decode_kind(input logic [13:0] w);
        if (w[13:8] == sbi_pkg::OP_DEC_SKIP)
            return sbi_pkg::KIND_DEC_SKIP;
        else if (w[13:8] == sbi_pkg::OP_INC_FILE)
            return sbi_pkg::KIND_INC;
        else if (w[13:11] == sbi_pkg::OP_JUMP)
            return sbi_pkg::KIND_JUMP;
        else
            return sbi_pkg::KIND_OTHER;
    endfunction

    // a word arriving in a flushed slot runs as idle op and is ignored
    always_comb
    begin
        kind = (instr_i.valid && !slot_idle_reg) ? decode_kind(instr_i.word)
                                                 : sbi_pkg::KIND_OTHER;
    end

    // file operand arrives combinationally for the address on the word
    sbi_alu u_alu
    (
        .operand_i(file_data_i),
        .down_i(kind == sbi_pkg::KIND_DEC_SKIP),
        .result_o(alu_result),
        .zero_o(alu_zero)
    );

    // ----------------------------------------------------------------
    // execute
    // ----------------------------------------------------------------
    logic [6:0] addr_reg;
    logic [6:0] addr_next;
    sbi_pkg::result_t result_reg;
    sbi_pkg::result_t result_next;
    sbi_pkg::flag_t flag_reg;
    sbi_pkg::flag_t flag_next;
    sbi_pkg::flow_t flow_reg;
    sbi_pkg::flow_t flow_next;

    // next values; one outcome per executed word
    always_comb
    begin
        addr_next = instr_i.word[6:0];
        result_next = '0;
        flag_next = '0;
        flow_next = '0;
        slot_idle_next = 1'b0;
        case (kind)
            sbi_pkg::KIND_DEC_SKIP:
            begin
                result_next.data = alu_result;
                result_next.addr = instr_i.word[6:0];
                result_next.file_we = instr_i.word[sbi_pkg::DEST_BIT];
                result_next.accum_we = !instr_i.word[sbi_pkg::DEST_BIT];
                flow_next.discard = alu_zero;
                slot_idle_next = alu_zero;
            end
            sbi_pkg::KIND_INC:
            begin
                result_next.data = alu_result;
                result_next.addr = instr_i.word[6:0];
                result_next.file_we = instr_i.word[sbi_pkg::DEST_BIT];
                result_next.accum_we = !instr_i.word[sbi_pkg::DEST_BIT];
                flag_next.zero_we = 1'b1;
                flag_next.zero_val = alu_zero;
            end
            sbi_pkg::KIND_JUMP:
            begin
                flow_next.pc[10:0] = instr_i.word[10:0];
                flow_next.pc[12:11] = pc_upper_latch_i[sbi_pkg::JUMP_HI_LSB +: 2];
                // flush makes the second cycle idle
                flow_next.pc_load = 1'b1;
                flow_next.discard = 1'b1;
                slot_idle_next = 1'b1;
            end
            sbi_pkg::KIND_OTHER:
            begin
                slot_idle_next = 1'b0;
            end
            default:
            begin
                slot_idle_next = 1'b0;
            end
        endcase
    end

    // registers only; outputs come straight from these
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            addr_reg <= sbi_pkg::ADDR_RST;
            result_reg <= '0;
            flag_reg <= '0;
            flow_reg <= '0;
            slot_idle_reg <= 1'b0;
        end
        else
        begin
            addr_reg <= addr_next;
            result_reg <= result_next;
            flag_reg <= flag_next;
            flow_reg <= flow_next;
            slot_idle_reg <= slot_idle_next;
        end
    end

    // registered copy of the last word's address for the register file
    always_comb
    begin
        file_addr_o = addr_reg;
        result_o = result_reg;
        flag_o = flag_reg;
        flow_o = flow_reg;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_dec_no_flag: assert property (
        kind == sbi_pkg::KIND_DEC_SKIP |=> !flag_o.zero_we &&
            result_o.data == 8'($past(file_data_i) - 8'h01))
        else $error("decrement result or flag wrong");

    a_dest_select: assert property (
        kind inside {sbi_pkg::KIND_DEC_SKIP, sbi_pkg::KIND_INC} |=>
            result_o.file_we == $past(instr_i.word[7]) &&
            result_o.accum_we == !$past(instr_i.word[7]))
        else $error("destination select wrong");

    a_skip_zero: assert property (
        kind == sbi_pkg::KIND_DEC_SKIP && file_data_i == 8'h01 |=>
            flow_o.discard ##1 (result_o == '0 && !flow_o.pc_load))
        else $error("skip slot not idle");

    a_jump_low: assert property (
        kind == sbi_pkg::KIND_JUMP |=>
            flow_o.pc_load && flow_o.pc[10:0] == $past(instr_i.word[10:0]))
        else $error("jump low bits wrong");

    a_jump_high: assert property (
        kind == sbi_pkg::KIND_JUMP |=> flow_o.pc[12:11] == $past(pc_upper_latch_i[4:3]))
        else $error("jump high bits wrong");

    a_jump_two: assert property (
        kind == sbi_pkg::KIND_JUMP |=> !flag_o.zero_we ##1 (!flow_o.pc_load && !flag_o.zero_we))
        else $error("jump not two cycles");

    a_inc_zero: assert property (
        kind == sbi_pkg::KIND_INC |=> flag_o.zero_we && !flow_o.discard)
        else $error("increment flag or skip wrong");

    a_wrap_zero: assert property (
        kind == sbi_pkg::KIND_INC && file_data_i == 8'hff |=>
            result_o.data == 8'h00 && flag_o.zero_val)
        else $error("wrap or zero flag wrong");

    a_keep_next: assert property (
        kind == sbi_pkg::KIND_DEC_SKIP && file_data_i != 8'h01 |=>
            !flow_o.discard && !flow_o.pc_load)
        else $error("nonzero decrement dropped the next word");

    a_inc_sum: assert property (
        kind == sbi_pkg::KIND_INC |=> result_o.data == 8'($past(file_data_i) + 8'h01) &&
            flag_o.zero_val == (result_o.data == 8'h00))
        else $error("increment sum or zero value wrong");

    c_skip: cover property (kind == sbi_pkg::KIND_DEC_SKIP && alu_zero);
    c_dec_plain: cover property (kind == sbi_pkg::KIND_DEC_SKIP && !alu_zero);
    c_jump: cover property (kind == sbi_pkg::KIND_JUMP);
    c_inc_wrap: cover property (kind == sbi_pkg::KIND_INC && alu_zero);

endmodule

/* File: bench/testbench.sv */
// self-checking bench for the skip, branch and increment decoder
`timescale 1ns/100ps
module testbench;

    // ------------------------------------------------------------
    // clock, reset and design signals
    // ------------------------------------------------------------
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    sbi_pkg::instr_t instr_i = '0;
    logic [7:0] file_data_i = 8'h00;
    logic [7:0] pc_upper_latch_i = 8'h00;
    logic [6:0] file_addr_o;
    sbi_pkg::result_t result_o;
    sbi_pkg::flag_t flag_o;
    sbi_pkg::flow_t flow_o;
    int err_count = 0;
    int n_compared = 0;

    // 125 MHz core clock
    always #4 clk_i = ~clk_i;

    skip_branch_increment_decode dut_u
    (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .instr_i(instr_i),
        .file_data_i(file_data_i),
        .pc_upper_latch_i(pc_upper_latch_i),
        .file_addr_o(file_addr_o),
        .result_o(result_o),
        .flag_o(flag_o),
        .flow_o(flow_o)
    );

    // ------------------------------------------------------------
    // drivers and compare tasks
    // ------------------------------------------------------------
    task automatic fail(input string msg);
        $display("unexpected at %0t: %s", $time, msg);
        err_count++;
    endtask

    // the operand address output trails the word by one edge
    task automatic chk_addr(input logic [6:0] adr);
        n_compared++;
        if (file_addr_o !== adr) fail("operand address");
    endtask

    // word goes in at the fall, its answer is read just after the next rise
    task automatic step(input logic vld, input logic [13:0] w, input logic [7:0] fd,
                        input logic [7:0] lt);
        @(negedge clk_i);
        instr_i <= {vld, w};
        file_data_i <= fd;
        pc_upper_latch_i <= lt;
        @(posedge clk_i);
        #1;
        chk_addr(w[6:0]);
    endtask

    // address and data only matter while a write strobe is up
    task automatic chk_res(input logic acc, input logic fil, input logic [6:0] adr,
                           input logic [7:0] dat);
        n_compared++;
        if (result_o.accum_we !== acc || result_o.file_we !== fil) fail("write strobes");
        else if ((acc || fil) && {result_o.addr, result_o.data} !== {adr, dat})
            fail("result value");
    endtask

    task automatic chk_flag(input logic we, input logic val);
        n_compared++;
        if (flag_o.zero_we !== we || (we && flag_o.zero_val !== val)) fail("zero flag");
    endtask

    task automatic chk_flow(input logic ld, input logic dis, input logic [12:0] pc);
        n_compared++;
        if (flow_o.pc_load !== ld || flow_o.discard !== dis) fail("flow strobes");
        else if (ld && flow_o.pc !== pc) fail("branch target");
    endtask

    // an ignored slot or a foreign opcode leaves every strobe low
    task automatic chk_quiet();
        chk_res(1'b0, 1'b0, 7'h00, 8'h00);
        chk_flag(1'b0, 1'b0);
        chk_flow(1'b0, 1'b0, 13'h0000);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_dec_skip();
        step(1'b1, 14'h0bff, 8'h01, 8'h00);
        chk_res(1'b0, 1'b1, 7'h7f, 8'h00);
        chk_flag(1'b0, 1'b0);
        chk_flow(1'b0, 1'b1, 13'h0000);
        step(1'b1, 14'h0a05, 8'h10, 8'h00);
        chk_quiet();
        // nonzero result wraps downward and takes one cycle only
        step(1'b1, 14'h0b23, 8'h00, 8'h00);
        chk_res(1'b1, 1'b0, 7'h23, 8'hff);
        chk_flag(1'b0, 1'b0);
        chk_flow(1'b0, 1'b0, 13'h0000);
        $display("test dec_skip done");
    endtask

    task automatic t_jump();
        step(1'b1, 14'h2d55, 8'h08, 8'h08);
        chk_flow(1'b1, 1'b1, 13'h0d55);
        chk_flag(1'b0, 1'b0);
        chk_res(1'b0, 1'b0, 7'h00, 8'h00);
        step(1'b1, 14'h0a01, 8'h00, 8'h08);
        chk_quiet();
        // latch bits other than 4:3 must not leak into the target
        step(1'b1, 14'h2fff, 8'h00, 8'hf7);
        chk_flow(1'b1, 1'b1, 13'h17ff);
        step(1'b1, 14'h2800, 8'h00, 8'he7);
        chk_quiet();
        $display("test jump done");
    endtask

    task automatic t_inc();
        step(1'b1, 14'h0a11, 8'hff, 8'h00);
        chk_res(1'b1, 1'b0, 7'h11, 8'h00);
        chk_flag(1'b1, 1'b1);
        chk_flow(1'b0, 1'b0, 13'h0000);
        step(1'b1, 14'h0aff, 8'h41, 8'h00);
        chk_res(1'b0, 1'b1, 7'h7f, 8'h42);
        chk_flag(1'b1, 1'b0);
        step(1'b1, 14'h0300, 8'h05, 8'h00);
        chk_quiet();
        $display("test inc done");
    endtask

    // reset in mid-run must drop the idle slot a jump has just armed
    task automatic t_reset();
        step(1'b1, 14'h2d55, 8'h00, 8'h08);
        chk_flow(1'b1, 1'b1, 13'h0d55);
        @(negedge clk_i);
        sys_rst_i = 1'b1;
        instr_i <= '0;
        @(posedge clk_i);
        #1;
        chk_quiet();
        // word presented at release is taken on the very first edge
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        instr_i <= {1'b1, 14'h0a11};
        file_data_i <= 8'h00;
        @(posedge clk_i);
        #1;
        chk_addr(7'h11);
        chk_res(1'b1, 1'b0, 7'h11, 8'h01);
        chk_flag(1'b1, 1'b0);
        $display("test reset done");
    endtask

    task automatic report_and_stop();
        $display("compared %0d, mismatched %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
        begin
            $display("Finished cleanly");
        end
        else
        begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence and run limit
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(negedge clk_i);
        sys_rst_i = 1'b0;
        step(1'b0, 14'h0000, 8'h00, 8'h00);
        chk_quiet();
        t_dec_skip();
        t_jump();
        t_inc();
        t_reset();
        report_and_stop();
    end

    // guards against a hang in the sequence above
    initial
    begin
        #100000;
        fail("run limit reached");
        report_and_stop();
    end

endmodule
